// [core/cwsr_defs.svh]
// register indices, field positions and reset values of the window-stop register bank
`ifndef CWSR_DEFS_SVH
`define CWSR_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define CWSR_IDX_RAM_ADDR_LO 6'h08
`define CWSR_IDX_RAM_ADDR_HI 6'h09
`define CWSR_IDX_RAM_DATA 6'h0A
`define CWSR_IDX_END_X_LO 6'h12
`define CWSR_IDX_END_X_HI 6'h13
`define CWSR_IDX_END_Y_LO 6'h16
`define CWSR_IDX_END_Y_HI 6'h17
`define CWSR_IDX_COL0_RED 6'h23
`define CWSR_IDX_COL0_GREEN 6'h24
`define CWSR_IDX_COL0_BLUE 6'h25
`define CWSR_IDX_COL1_RED 6'h26
`define CWSR_IDX_COL1_GREEN 6'h27
`define CWSR_IDX_COL1_BLUE 6'h28

// field layout
`define CWSR_COORD_HI_MSB 3
`define CWSR_RAM_ADDR_HI_MSB 1
`define CWSR_PIX_BITS 2

// values loaded by the bus reset into registers that have no documented reset value
`define CWSR_RST_BYTE 8'h00
`define CWSR_RST_COORD 12'h000
`define CWSR_RST_WORD 32'h0000_0000

`endif

// [core/cwsr_pkg.sv]
// types shared by the window-stop register bank
package cwsr_pkg;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } cwsr_color_type;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
  } cwsr_point_type;

endpackage : cwsr_pkg

// [core/cwsr_regs.sv]
// window-stop, cursor-colour and sprite-ram access registers behind a wishbone slave
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "cwsr_defs.svh"

// Operation
// [R1] x stop is low byte at 12h plus high nibble at 13h, twelve bits
// [R2] y stop is low byte at 16h plus high nibble at 17h, twelve bits
// [R3] bits 7..4 of both stop high bytes always read zero
// [R4] new stop values take effect only at retrace after y-high write
// [R5] stop registers have no defined reset; accesses accepted any time
// [R6] host writes stop coordinates 000..FFF relative to first pixel
// [R7] stop position is the last pixel inside the window
// [R8] host puts window start inside the active display
// [R9] two cursor colours, red green blue bytes at 23h..25h and 26h..28h
// [R10] colour registers take any byte, no reset value, access any time
// [R11] sprite ram address is low byte at 08h plus two bits at 09h
// [R12] bits 7..2 of sprite address high byte always read zero
// [R13] host writes address low byte first, range 000..3FF
// [R14] data port at 0Ah reaches sprite ram at the current address
// [R15] each ram byte holds four pixels of two planes, pixel 3 on top
// [R16] data port takes any byte, no reset value, access any time
// [R17] start position is the first pixel inside the window
// [R18] x and y stop move to active together at the retrace transfer
// [R19] stop reads return last written value, shadow included, reserved zero
module cwsr_regs #(
  parameter int RAM_DEPTH = 1024
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // display timing and pixel position
  input wire logic vretrace_i,
  input wire logic [11:0] pix_x_i,
  input wire logic [11:0] pix_y_i,
  input wire cwsr_pkg::cwsr_point_type win_start_i,
  // sprite fetch from the cursor datapath
  input wire logic [9:0] sprite_addr_i,
  input wire logic [1:0] sprite_pix_sel_i,
  // outputs to the display datapath
  output cwsr_pkg::cwsr_point_type win_end_o,
  output logic in_window_o,
  output cwsr_pkg::cwsr_color_type color0_o,
  output cwsr_pkg::cwsr_color_type color1_o,
  output logic [`CWSR_PIX_BITS-1:0] sprite_pix_o
);

  logic [7:0] sprite_mem [0:RAM_DEPTH-1];

  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] end_x_lo_ff;
  logic [3:0] end_x_hi_ff;
  logic [7:0] end_y_lo_ff;
  logic [3:0] end_y_hi_ff;
  logic [7:0] ram_addr_lo_ff;
  logic [1:0] ram_addr_hi_ff;
  cwsr_pkg::cwsr_color_type color0_ff;
  cwsr_pkg::cwsr_color_type color1_ff;
  cwsr_pkg::cwsr_point_type win_end_ff;
  logic pending_ff;
  logic vret_d_ff;
  logic in_window_ff;
  logic [`CWSR_PIX_BITS-1:0] sprite_pix_ff;

  logic req;
  logic wr;
  logic [5:0] idx;
  logic [7:0] wbyte;
  logic [9:0] ram_addr;
  logic wr_end_y_hi;
  logic vret_rise;
  logic transfer;
  logic [7:0] fetch_byte;

  // a request is served once; req is masked in the ack cycle so stb, still high while ack is seen, cannot repeat it
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[7:2];
  assign wbyte = wb_dat_i[7:0];
  assign ram_addr = {ram_addr_hi_ff, ram_addr_lo_ff}; // [R11]
  assign wr_end_y_hi = wr && (idx == `CWSR_IDX_END_Y_HI);
  assign vret_rise = vretrace_i && !vret_d_ff;
  // a y-high write in the edge cycle wins and waits for the next retrace
  assign transfer = vret_rise && pending_ff && !wr_end_y_hi; // [R4]
  assign fetch_byte = sprite_mem[sprite_addr_i];

  // bus handshake: ack one cycle after the request, then drop [R5]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // read mux; unmapped indices read zero, upper lanes always zero
  always_comb begin
    nxt_rdata = `CWSR_RST_WORD;
    case (idx)
      `CWSR_IDX_RAM_ADDR_LO: nxt_rdata[7:0] = ram_addr_lo_ff;
      `CWSR_IDX_RAM_ADDR_HI: nxt_rdata[1:0] = ram_addr_hi_ff; // [R12]
      `CWSR_IDX_RAM_DATA: nxt_rdata[7:0] = sprite_mem[ram_addr]; // [R14]
      `CWSR_IDX_END_X_LO: nxt_rdata[7:0] = end_x_lo_ff; // [R19]
      `CWSR_IDX_END_X_HI: nxt_rdata[3:0] = end_x_hi_ff; // [R3]
      `CWSR_IDX_END_Y_LO: nxt_rdata[7:0] = end_y_lo_ff; // [R19]
      `CWSR_IDX_END_Y_HI: nxt_rdata[3:0] = end_y_hi_ff; // [R3]
      `CWSR_IDX_COL0_RED: nxt_rdata[7:0] = color0_ff.red;
      `CWSR_IDX_COL0_GREEN: nxt_rdata[7:0] = color0_ff.green;
      `CWSR_IDX_COL0_BLUE: nxt_rdata[7:0] = color0_ff.blue;
      `CWSR_IDX_COL1_RED: nxt_rdata[7:0] = color1_ff.red;
      `CWSR_IDX_COL1_GREEN: nxt_rdata[7:0] = color1_ff.green;
      `CWSR_IDX_COL1_BLUE: nxt_rdata[7:0] = color1_ff.blue;
      default: nxt_rdata = `CWSR_RST_WORD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= `CWSR_RST_WORD;
    end else if (req && !wb_we_i) begin
      rdata_ff <= nxt_rdata;
    end else if (!req) begin
      rdata_ff <= `CWSR_RST_WORD;
    end
  end

  // window-stop shadow bytes; only the low nibble of each high byte is kept [R1] [R2]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      end_x_lo_ff <= `CWSR_RST_BYTE;
      end_x_hi_ff <= 4'h0;
      end_y_lo_ff <= `CWSR_RST_BYTE;
      end_y_hi_ff <= 4'h0;
    end else if (wr) begin
      case (idx)
        `CWSR_IDX_END_X_LO: end_x_lo_ff <= wbyte;
        `CWSR_IDX_END_X_HI: end_x_hi_ff <= wbyte[`CWSR_COORD_HI_MSB:0]; // [R3]
        `CWSR_IDX_END_Y_LO: end_y_lo_ff <= wbyte;
        `CWSR_IDX_END_Y_HI: end_y_hi_ff <= wbyte[`CWSR_COORD_HI_MSB:0]; // [R3]
        default: begin
        end
      endcase
    end
  end

  // retrace transfer: armed by the y-high write, fired at the next retrace rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_ff <= 1'b0;
      vret_d_ff <= 1'b0;
    end else begin
      vret_d_ff <= vretrace_i;
      if (wr_end_y_hi) begin
        pending_ff <= 1'b1; // [R4]
      end else if (transfer) begin
        pending_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_end_ff <= {`CWSR_RST_COORD, `CWSR_RST_COORD};
    end else if (transfer) begin
      // both axes in one step so the active corner never mixes old and new
      win_end_ff.x <= {end_x_hi_ff, end_x_lo_ff}; // [R18] [R1]
      win_end_ff.y <= {end_y_hi_ff, end_y_lo_ff}; // [R18] [R2]
    end
  end

  // inclusive window compare on both corners [R7] [R17]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_window_ff <= 1'b0;
    end else begin
      in_window_ff <= (pix_x_i >= win_start_i.x) && (pix_x_i <= win_end_ff.x)
        && (pix_y_i >= win_start_i.y) && (pix_y_i <= win_end_ff.y); // [R7] [R17]
    end
  end

  // cursor colours take any byte [R9] [R10]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      color0_ff <= {`CWSR_RST_BYTE, `CWSR_RST_BYTE, `CWSR_RST_BYTE};
      color1_ff <= {`CWSR_RST_BYTE, `CWSR_RST_BYTE, `CWSR_RST_BYTE};
    end else if (wr) begin
      case (idx)
        `CWSR_IDX_COL0_RED: color0_ff.red <= wbyte; // [R9]
        `CWSR_IDX_COL0_GREEN: color0_ff.green <= wbyte;
        `CWSR_IDX_COL0_BLUE: color0_ff.blue <= wbyte;
        `CWSR_IDX_COL1_RED: color1_ff.red <= wbyte; // [R9]
        `CWSR_IDX_COL1_GREEN: color1_ff.green <= wbyte;
        `CWSR_IDX_COL1_BLUE: color1_ff.blue <= wbyte; // [R10]
        default: begin
        end
      endcase
    end
  end

  // sprite address; no auto-increment, so software reloads it per byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_addr_lo_ff <= `CWSR_RST_BYTE;
      ram_addr_hi_ff <= 2'h0;
    end else if (wr && (idx == `CWSR_IDX_RAM_ADDR_LO)) begin
      ram_addr_lo_ff <= wbyte; // [R11]
    end else if (wr && (idx == `CWSR_IDX_RAM_ADDR_HI)) begin
      ram_addr_hi_ff <= wbyte[`CWSR_RAM_ADDR_HI_MSB:0]; // [R12]
    end
  end

  // sprite ram is not reset: contents are undefined until written [R16]
  always_ff @(posedge clk_i) begin
    if (wr && (idx == `CWSR_IDX_RAM_DATA)) begin
      sprite_mem[ram_addr] <= wbyte; // [R14] [R16]
    end
  end

  // pixel n sits at bits 2n+1 (plane 1) and 2n (plane 0)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sprite_pix_ff <= 2'h0;
    end else begin
      sprite_pix_ff <= fetch_byte[{sprite_pix_sel_i, 1'b0} +: `CWSR_PIX_BITS]; // [R15]
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign win_end_o = win_end_ff;
  assign in_window_o = in_window_ff;
  assign color0_o = color0_ff;
  assign color1_o = color1_ff;
  assign sprite_pix_o = sprite_pix_ff;

  a_stop_hi_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (req && !wb_we_i && (idx == `CWSR_IDX_END_X_HI || idx == `CWSR_IDX_END_Y_HI))
    |=> (wb_dat_o[7:4] == 4'h0))
    else $error("stop high byte reserved bits not zero");

  a_addr_hi_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (req && !wb_we_i && idx == `CWSR_IDX_RAM_ADDR_HI) |=> (wb_dat_o[7:2] == 6'h00))
    else $error("sprite address high reserved bits not zero");

  a_stop_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    !(vretrace_i && !vret_d_ff) |=> $stable(win_end_o))
    else $error("active stop changed outside a retrace rise");

  a_stop_x_join: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    transfer |=> (win_end_o.x == {$past(end_x_hi_ff), $past(end_x_lo_ff)}))
    else $error("x stop not joined from its two bytes");

  a_stop_y_join: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    transfer |=> (win_end_o.y == {$past(end_y_hi_ff), $past(end_y_lo_ff)}))
    else $error("y stop not joined from its two bytes");

  a_stop_together: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    $changed(win_end_o.x) |-> $past(transfer) && ($past(pending_ff) && !pending_ff))
    else $error("x stop moved without a full transfer");

  // a master that idles one cycle after ack presents its next request three edges later
  a_stop_readback: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    (wr && idx == `CWSR_IDX_END_X_LO) ##3 (req && !wb_we_i && idx == `CWSR_IDX_END_X_LO)
    |=> (wb_dat_o[7:0] == $past(wbyte, 4)))
    else $error("x stop low readback differs from last write");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after the request");

  a_col1_red: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (wr && idx == `CWSR_IDX_COL1_RED) |=> (color1_o.red == $past(wbyte)))
    else $error("colour 1 red not written");

  a_ram_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (wr && idx == `CWSR_IDX_RAM_DATA) ##3 (req && !wb_we_i && idx == `CWSR_IDX_RAM_DATA)
    |=> (wb_dat_o[7:0] == $past(wbyte, 4)))
    else $error("sprite data readback differs from write");

  a_win_corner: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (pix_x_i == win_end_o.x && pix_y_i == win_end_o.y && win_start_i.x <= pix_x_i
      && win_start_i.y <= pix_y_i) |=> in_window_o)
    else $error("stop corner pixel not inside window");

  a_win_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (pix_x_i == win_start_i.x && pix_y_i == win_start_i.y && pix_x_i <= win_end_o.x
      && pix_y_i <= win_end_o.y) |=> in_window_o)
    else $error("start corner pixel not inside window");

  a_stop_y_moved: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    $changed(win_end_o.y) |-> $past(transfer))
    else $error("y stop moved without a transfer");

  // the arming write must not fire a transfer in its own cycle
  a_stop_wait: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    wr_end_y_hi |=> $stable(win_end_o))
    else $error("active stop moved in the y-high write cycle");

  a_pend_arm: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    wr_end_y_hi |=> pending_ff)
    else $error("y-high write did not arm the transfer");

  a_y_hi_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (wr && idx == `CWSR_IDX_END_Y_HI) |=> ({4'h0, end_y_hi_ff} == ($past(wbyte) & 8'h0F)))
    else $error("y stop high nibble not stored");

  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");

  a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data not zero outside an answer");

  a_rdata_upper: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");

  a_col0_red: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (wr && idx == `CWSR_IDX_COL0_RED) |=> (color0_o.red == $past(wbyte)))
    else $error("colour 0 red not written");

  a_col0_blue: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (wr && idx == `CWSR_IDX_COL0_BLUE) |=> (color0_o.blue == $past(wbyte)))
    else $error("colour 0 blue not written");

  a_col1_green: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (wr && idx == `CWSR_IDX_COL1_GREEN) |=> (color1_o.green == $past(wbyte)))
    else $error("colour 1 green not written");

  a_addr_lo_load: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (wr && idx == `CWSR_IDX_RAM_ADDR_LO) |=> (ram_addr[7:0] == $past(wbyte)))
    else $error("sprite address low byte not loaded");

  a_addr_hi_load: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (wr && idx == `CWSR_IDX_RAM_ADDR_HI) |=> ({6'h00, ram_addr[9:8]} == ($past(wbyte) & 8'h03)))
    else $error("sprite address high bits not loaded");

  // a pixel right of the stop or left of the start is outside
  a_win_right: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (pix_x_i > win_end_o.x) |=> !in_window_o)
    else $error("pixel past the stop counted inside");

  a_win_left: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (pix_x_i < win_start_i.x) |=> !in_window_o)
    else $error("pixel before the start counted inside");

endmodule : cwsr_regs

// [test/cwsr_disp_model.sv]
// display raster model driving pixel position and vertical retrace
`timescale 1ns/1ps
module cwsr_disp_model #(
  parameter int HT = 16,
  parameter int VT = 8,
  parameter int VACT = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raster outputs
  output logic [11:0] pix_x_o,
  output logic [11:0] pix_y_o,
  output logic vretrace_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_x_o <= 12'h000;
      pix_y_o <= 12'h000;
    end else if (pix_x_o == 12'(HT - 1)) begin
      pix_x_o <= 12'h000;
      pix_y_o <= (pix_y_o == 12'(VT - 1)) ? 12'h000 : pix_y_o + 12'h001;
    end else begin
      pix_x_o <= pix_x_o + 12'h001;
    end
  end
  // tiny raster keeps frames short; retrace spans the last lines
  assign vretrace_o = (pix_y_o >= 12'(VACT));
endmodule : cwsr_disp_model

// [test/cursor_window_stop_regs_tb.sv]
// self-checking bench for the window-stop register bank
`timescale 1ns/1ps
`include "cwsr_defs.svh"
module cursor_window_stop_regs_tb;
  logic clk_i, rst_i, cyc, stb, we, ack, vr, vr_ff, pend_ff, inw_o, exp_in_ff, cyc_ff, tk, ywr;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [11:0] px, py;
  logic [1:0] spix, psel;
  logic [9:0] sadr;
  cwsr_pkg::cwsr_point_type start, wend, act_ff, shd_ff;
  cwsr_pkg::cwsr_color_type c0, c1;
  int n_errors = 0;
  int checked = 0;

  cwsr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .vretrace_i(vr), .pix_x_i(px), .pix_y_i(py), .win_start_i(start),
    .sprite_addr_i(sadr), .sprite_pix_sel_i(psel), .win_end_o(wend), .in_window_o(inw_o),
    .color0_o(c0), .color1_o(c1), .sprite_pix_o(spix));
  cwsr_disp_model disp_u (.clk_i(clk_i), .rst_i(rst_i), .pix_x_o(px), .pix_y_o(py),
    .vretrace_o(vr));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(32'(n), 32'h2, "ack_latency");
  endtask : wb

  function automatic logic inw(input logic [11:0] x, input logic [11:0] y,
      input cwsr_pkg::cwsr_point_type s, input cwsr_pkg::cwsr_point_type e);
    return x >= s.x && x <= e.x && y >= s.y && y <= e.y;
  endfunction : inw

  // a request is taken at the first edge of its cycle; cyc idles between requests
  assign tk = cyc && stb && we && sel[0] && !cyc_ff;
  assign ywr = tk && (adr[7:2] == `CWSR_IDX_END_Y_HI);

  // active stop moves only at a retrace rise after a y-high write
  always @(posedge clk_i) begin
    if (rst_i) begin
      vr_ff <= 1'b0;
      cyc_ff <= 1'b0;
      exp_in_ff <= 1'b0;
      act_ff <= '0;
      shd_ff <= '0;
      pend_ff <= 1'b0;
    end else begin
      chk(32'(wend), 32'(act_ff), "win_end");
      chk(32'(inw_o), 32'(exp_in_ff), "in_window");
      exp_in_ff <= inw(px, py, start, act_ff);
      vr_ff <= vr;
      cyc_ff <= cyc;
      if (tk) begin
        case (adr[7:2])
          `CWSR_IDX_END_X_LO: shd_ff.x[7:0] <= dat[7:0];
          `CWSR_IDX_END_X_HI: shd_ff.x[11:8] <= dat[3:0];
          `CWSR_IDX_END_Y_LO: shd_ff.y[7:0] <= dat[7:0];
          `CWSR_IDX_END_Y_HI: shd_ff.y[11:8] <= dat[3:0];
          default: begin
          end
        endcase
      end
      // an arming write on the rise edge wins and waits for the next retrace
      if (ywr) begin
        pend_ff <= 1'b1;
      end else if (vr && !vr_ff && pend_ff) begin
        act_ff <= shd_ff;
        pend_ff <= 1'b0;
      end
    end
  end

  initial begin
    #200000;
    n_errors++;
    complete_run;
  end

  initial begin
    logic [7:0] q, d;
    logic [7:0] col [6];
    logic [9:0] a;
    logic [11:0] ex, ey;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0;
    start = '0;
    sadr = 10'h000;
    psel = 2'h0;
    void'($urandom(91804));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      col[i] = (i == 0) ? 8'h00 : (i == 5) ? 8'hFF : 8'($urandom);
      wb(1'b1, 6'h23 + 6'(i), col[i], q);
    end
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 6'h23 + 6'(i), 8'h00, q);
      chk(32'(q), 32'(col[i]), "color_rd");
    end
    chk(32'(c0), {8'h00, col[0], col[1], col[2]}, "color0");
    chk(32'(c1), {8'h00, col[3], col[4], col[5]}, "color1");
    // a write with lane 0 disabled must leave the register alone
    sel <= 4'hE;
    wb(1'b1, `CWSR_IDX_COL1_RED, ~col[3], q);
    sel <= 4'hF;
    wb(1'b0, `CWSR_IDX_COL1_RED, 8'h00, q);
    chk(32'(q), 32'(col[3]), "sel_masked");
    wb(1'b1, 6'h3F, 8'hFF, q);
    wb(1'b0, 6'h3F, 8'h00, q);
    chk(32'(q), 32'h0, "unmapped");
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($urandom);
      d = 8'($urandom);
      wb(1'b1, `CWSR_IDX_RAM_ADDR_LO, a[7:0], q);
      wb(1'b1, `CWSR_IDX_RAM_ADDR_HI, {6'($urandom), a[9:8]}, q);
      wb(1'b0, `CWSR_IDX_RAM_ADDR_HI, 8'h00, q);
      chk(32'(q), 32'(a[9:8]), "ram_addr_hi");
      wb(1'b1, `CWSR_IDX_RAM_DATA, d, q);
      wb(1'b0, `CWSR_IDX_RAM_DATA, 8'h00, q);
      chk(32'(q), 32'(d), "ram_data");
      sadr <= a;
      for (int j = 0; j < 4; j++) begin
        psel <= 2'(j);
        repeat (2) @(posedge clk_i);
        chk(32'(spix), 32'(d[2*j +: 2]), "sprite_pix");
      end
    end
    // writes land mid-retrace, so they must wait a whole frame
    for (int p = 0; p < 2; p++) begin
      ex = p ? 12'h005 : 12'($urandom);
      ey = p ? 12'h003 : 12'($urandom);
      while (vr !== 1'b1) begin
        @(posedge clk_i);
      end
      start <= p ? 24'h002001 : {12'($urandom_range(15)), 12'($urandom_range(5))};
      wb(1'b1, `CWSR_IDX_END_X_LO, ex[7:0], q);
      wb(1'b0, `CWSR_IDX_END_X_LO, 8'h00, q);
      chk(32'(q), 32'(ex[7:0]), "end_x_lo");
      wb(1'b1, `CWSR_IDX_END_X_HI, {4'($urandom), ex[11:8]}, q);
      wb(1'b1, `CWSR_IDX_END_Y_LO, ey[7:0], q);
      wb(1'b1, `CWSR_IDX_END_Y_HI, {4'($urandom), ey[11:8]}, q);
      wb(1'b0, `CWSR_IDX_END_X_HI, 8'h00, q);
      chk(32'(q), 32'(ex[11:8]), "end_x_hi");
      wb(1'b0, `CWSR_IDX_END_Y_HI, 8'h00, q);
      chk(32'(q), 32'(ey[11:8]), "end_y_hi");
      wb(1'b0, `CWSR_IDX_END_Y_LO, 8'h00, q);
      chk(32'(q), 32'(ey[7:0]), "end_y_lo");
      repeat (300) @(posedge clk_i);
    end
    complete_run;
  end
endmodule : cursor_window_stop_regs_tb
